//--- include/ebhg_pkg.sv
// Purpose: Shared constants and types for the external bus hold/grant block
// Assumes: One clock, 10 MHz, synchronous active-high reset
// Notes: All timing counts are in CPU clock periods
package ebhg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int MIN_FLOAT_P = 4;          // Request low to bus float, least
  localparam int MAX_GRANT_P = 2;          // Float to grant low, most
  localparam int MIN_DROP_P = 4;           // Request high to grant high, least
  localparam int MAX_DROP_P = 7;           // Request high to grant high, most
  localparam int MIN_DRIVE_P = 3;          // Request high to bus driven, least
  localparam int MAX_DRIVE_P = 6;          // Request high to bus driven, most
  localparam int SYNC_STAGES = 2;
  localparam int BURST_KEEP_MIN = 8;       // Least SDRAM accesses kept
  localparam int CNT_W = 4;

  // Counts from the request pin edge; the synchroniser eats SYNC_STAGES cycles
  localparam logic [CNT_W-1:0] FLOAT_WAIT = CNT_W'(MIN_FLOAT_P - SYNC_STAGES);
  localparam logic [CNT_W-1:0] DRIVE_WAIT = CNT_W'(MIN_DRIVE_P + 1 - SYNC_STAGES);
  localparam logic [CNT_W-1:0] DROP_WAIT = CNT_W'(MIN_DROP_P + 1 - SYNC_STAGES);
  localparam logic [CNT_W-1:0] BURST_KEEP = CNT_W'(BURST_KEEP_MIN);

  // ----------------------------------------------------------------
  // Bus pin widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 20;
  localparam int CE_W = 4;
  localparam int BE_W = 4;

  // Output enables are low while driving
  localparam logic OE_DRIVE = 1'b0;
  localparam logic OE_FLOAT = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    EBHG_OWN     = 3'h0,
    EBHG_DRAIN   = 3'h1,
    EBHG_FLOAT   = 3'h2,
    EBHG_HELD    = 3'h3,
    EBHG_RELEASE = 3'h4,
    EBHG_DRIVE   = 3'h5
  } ebhg_state_t;

  // Bus pin values driven by the memory controller
  typedef struct packed {
    logic [CE_W-1:0] chip_enables_n;
    logic [BE_W-1:0] byte_lane_enables_n;
    logic [DATA_W-1:0] ext_data_lines;
    logic [ADDR_W-1:0] ext_addr_lines;
    logic async_read_strobe_n;
    logic async_output_en_n;
    logic async_write_strobe_n;
    logic sbsram_addr_strobe_n;
    logic sbsram_output_en_n;
    logic sbsram_write_en_n;
    logic sdram_addr_bit_ten;
    logic sdram_row_strobe_n;
    logic sdram_col_strobe_n;
    logic sdram_write_en_n;
  } ebhg_bus_t;

  // Activity of the memory controller
  typedef struct packed {
    logic async_busy;      // Async access in progress
    logic sdram_busy;      // SDRAM access in progress
    logic sdram_access;    // One SDRAM read or write done this cycle
    logic other_busy;      // Any other pending access
  } ebhg_xact_t;

endpackage : ebhg_pkg

//--- core/ebhg_sync.sv
// Purpose: Two-flop synchroniser for the asynchronous bus request
// Assumes: Input may change at any time
// Notes: Resets to the idle (high) level
`timescale 1ns/1ps
`default_nettype none
module ebhg_sync
  import ebhg_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_sync
);

  logic meta;
  logic stable;
  logic next_meta;
  logic next_stable;

  // Next values of the two stages
  always_comb begin
    next_meta = i_async;
    next_stable = meta;
  end

  // First stage read only by the second
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      meta <= RESET_VAL;
      stable <= RESET_VAL;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
    end
  end

  assign o_sync = stable;

endmodule // ebhg_sync
`default_nettype wire

//--- core/ebhg_burst.sv
// Purpose: Tracks whether pending external traffic may be cut for a hold
// Assumes: Activity flags come from the memory controller in the same clock
// Notes: Counts consecutive SDRAM accesses toward the burst-keep minimum
`timescale 1ns/1ps
`default_nettype none
module ebhg_burst
  import ebhg_pkg::*;
#(
  parameter int KEEP = BURST_KEEP_MIN
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_sdram_burst_keep,
  input wire ebhg_xact_t i_xact,
  output logic o_idle
);

  // Keep count must fit the run counter; refused at elaboration
  if (KEEP < 1 || KEEP > 15) begin : g_keep_bad
    $error("ebhg_burst: KEEP out of range");
  end

  localparam logic [CNT_W-1:0] KEEP_CNT = CNT_W'(KEEP);

  logic [CNT_W-1:0] run;
  logic [CNT_W-1:0] next_run;

  // Consecutive SDRAM access count, saturating
  always_comb begin
    next_run = run;
    if (!i_xact.sdram_busy) begin
      next_run = '0;
    end else if (i_xact.sdram_access && run != KEEP_CNT) begin
      next_run = run + CNT_W'(1);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      run <= '0;
    end else begin
      run <= next_run;
    end
  end

  always_comb begin
    o_idle = !i_xact.async_busy && !i_xact.other_busy;
    if (i_xact.sdram_busy && (!i_sdram_burst_keep || run != KEEP_CNT)) begin
      o_idle = 1'b0;
    end
  end

endmodule // ebhg_burst
`default_nettype wire

//--- core/ebhg_top.sv
// Purpose: Bus hold and grant handshake of the external memory interface
// Assumes: Single 10 MHz clock, synchronous active-high reset
// Notes: Bus pins leave as value plus one shared active-low output enable
// Notes on behaviour
// - The bus request passes a two-flop synchroniser so it may be asynchronous.
// - The bus floats no sooner than four periods after the request falls.
// - The grant goes low at most two periods after the bus has floated.
// - The grant returns high four to seven periods after the request rises.
// - The bus is driven again three to six periods after the request rises.
// - Pending external accesses complete before the grant is given; with burst keep set an SDRAM burst is cut after eight accesses.
// - While grant inhibit is one the bus is not floated; a bus already floated is still granted.
// - A stretched async access and, with burst keep set, eight SDRAM accesses finish first.
// - Every bus output floats while the bus is held.
// - With no traffic the bus is released and granted at the least delay.
`timescale 1ns/1ps
`default_nettype none
module ebhg_top
  import ebhg_pkg::*;
#(
  parameter int BURST_KEEP_N = BURST_KEEP_MIN
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_bus_request_n,
  input wire logic i_grant_inhibit,
  input wire logic i_sdram_burst_keep,
  input wire ebhg_xact_t i_xact,
  input wire ebhg_bus_t i_bus,
  output logic o_hold_pending,
  output ebhg_bus_t o_bus,
  output logic o_bus_oe_n,
  output logic o_bus_grant_out_n
);

  // ----------------------------------------------------------------
  // Request synchronisation and traffic status
  // ----------------------------------------------------------------
  logic req_n_sync;
  logic traffic_idle;

  ebhg_sync #(
    .RESET_VAL(1'b1)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async(i_bus_request_n),
    .o_sync(req_n_sync)
  );

  ebhg_burst #(
    .KEEP(BURST_KEEP_N)
  ) u_burst (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_sdram_burst_keep(i_sdram_burst_keep),
    .i_xact(i_xact),
    .o_idle(traffic_idle)
  );

  // ----------------------------------------------------------------
  // Hold sequencer
  // ----------------------------------------------------------------
  ebhg_state_t state;
  ebhg_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic oe_n;
  logic next_oe_n;
  logic grant_n;
  logic next_grant_n;
  logic req_seen;

  assign req_seen = !req_n_sync;

  // Next state, counter, enable and grant
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_oe_n = oe_n;
    next_grant_n = grant_n;
    case (state)
      EBHG_OWN: begin
        next_cnt = CNT_W'(1);
        if (req_seen && !i_grant_inhibit) begin
          next_state = EBHG_DRAIN;
        end
      end
      EBHG_DRAIN: begin
        if (cnt != FLOAT_WAIT) begin
          next_cnt = cnt + CNT_W'(1);
        end
        if (!req_seen) begin
          next_state = EBHG_OWN;
        end else if (cnt == FLOAT_WAIT && traffic_idle && !i_grant_inhibit) begin
          next_state = EBHG_FLOAT;
          next_oe_n = OE_FLOAT;
        end
      end
      EBHG_FLOAT: begin
        next_state = EBHG_HELD;
        next_grant_n = 1'b0;
      end
      EBHG_HELD: begin
        next_cnt = CNT_W'(1);
        if (!req_seen == 1'b0) begin
          next_state = EBHG_HELD;
        end else begin
          next_state = EBHG_RELEASE;
        end
      end
      EBHG_RELEASE: begin
        next_cnt = cnt + CNT_W'(1);
        if (cnt == DRIVE_WAIT) begin
          next_oe_n = OE_DRIVE;
          next_state = EBHG_DRIVE;
        end
      end
      EBHG_DRIVE: begin
        next_cnt = cnt + CNT_W'(1);
        if (cnt == DROP_WAIT) begin
          next_grant_n = 1'b1;
          next_state = EBHG_OWN;
        end
      end
      default: begin
        next_state = EBHG_OWN;
        next_oe_n = OE_DRIVE;
        next_grant_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state <= EBHG_OWN;
      cnt <= '0;
      oe_n <= OE_DRIVE;
      grant_n <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      oe_n <= next_oe_n;
      grant_n <= next_grant_n;
    end
  end

  // ----------------------------------------------------------------
  // Bus pin register
  // ----------------------------------------------------------------
  ebhg_bus_t bus_q;
  ebhg_bus_t next_bus_q;

  // Value follows controller; parked at inactive levels while floated
  always_comb begin
    if (next_oe_n == OE_FLOAT) begin
      next_bus_q = '1;
    end else begin
      next_bus_q = i_bus;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      bus_q <= '1;
    end else begin
      bus_q <= next_bus_q;
    end
  end

  assign o_bus = bus_q;
  assign o_bus_oe_n = oe_n;
  assign o_bus_grant_out_n = grant_n;
  assign o_hold_pending = (state == EBHG_DRAIN);

endmodule // ebhg_top
`default_nettype wire

//--- tb/ebhg_master.sv
// Purpose: Outside bus master asking for the memory bus
// Assumes: The bench says when ownership is wanted
// Notes: The request pin moves 1 ns after a clock edge
`timescale 1ns/1ps
`default_nettype none
module ebhg_master (
  input wire logic i_mclk,
  input wire logic i_want,
  output logic o_bus_request_n
);
  // Request pin idles high and follows the bench command
  initial begin
    o_bus_request_n = 1'h1;
    forever begin
      @(posedge i_mclk);
      o_bus_request_n <= #1 !i_want;
    end
  end
endmodule // ebhg_master
`default_nettype wire

//--- tb/ebhg_chk_asserts.sv
// Purpose: Timing checks on the hold handshake pins
// Assumes: Sees only ebhg_top ports
// Notes: Windows counted in clock periods from the sampled pin edge
`timescale 1ns/1ps
`default_nettype none
module ebhg_chk
  import ebhg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_bus_request_n,
  input wire logic i_grant_inhibit,
  input wire ebhg_xact_t i_xact,
  input wire logic o_bus_oe_n,
  input wire logic o_bus_grant_out_n
);
  // ------------------------------
  // Handshake timing
  // ------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  property p_float_min;
    $fell(i_bus_request_n) && !o_bus_oe_n && o_bus_grant_out_n |-> !o_bus_oe_n [*5];
  endproperty
  a_float_min: assert property (p_float_min) else $error("bus floated early");
  property p_grant_fast;
    $rose(o_bus_oe_n) |-> ##[1:2] !o_bus_grant_out_n;
  endproperty
  a_grant_fast: assert property (p_grant_fast) else $error("grant late after float");
  property p_grant_floated;
    $fell(o_bus_grant_out_n) |-> o_bus_oe_n;
  endproperty
  a_grant_floated: assert property (p_grant_floated) else $error("grant while driving");
  property p_drop;
    $rose(i_bus_request_n) && !o_bus_grant_out_n |-> !o_bus_grant_out_n [*4] ##[1:4] o_bus_grant_out_n;
  endproperty
  a_drop: assert property (p_drop) else $error("grant release out of window");
  property p_drive;
    $rose(i_bus_request_n) && o_bus_oe_n |-> o_bus_oe_n [*3] ##[1:4] !o_bus_oe_n;
  endproperty
  a_drive: assert property (p_drive) else $error("bus drive out of window");
  property p_inhibit;
    i_grant_inhibit && !o_bus_oe_n && o_bus_grant_out_n |=> !o_bus_oe_n;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("bus floated while inhibited");
  property p_busy;
    i_xact.async_busy && $past(i_xact.async_busy) && !o_bus_oe_n |=> !o_bus_oe_n;
  endproperty
  a_busy: assert property (p_busy) else $error("bus floated mid access");
  property p_idle;
    $fell(i_bus_request_n) && o_bus_grant_out_n && !o_bus_oe_n && !i_grant_inhibit && i_xact == '0
      |-> ##6 !o_bus_grant_out_n;
  endproperty
  a_idle: assert property (p_idle) else $error("idle grant not at least delay");
  property p_reset;
    $fell(i_rst) |-> o_bus_grant_out_n && !o_bus_oe_n;
  endproperty
  a_reset: assert property (p_reset) else $error("wrong state after reset");
endmodule // ebhg_chk
bind ebhg_top ebhg_chk ebhg_chk_i (
  .i_mclk(i_mclk),
  .i_rst(i_rst),
  .i_bus_request_n(i_bus_request_n),
  .i_grant_inhibit(i_grant_inhibit),
  .i_xact(i_xact),
  .o_bus_oe_n(o_bus_oe_n),
  .o_bus_grant_out_n(o_bus_grant_out_n)
);
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the bus hold handshake
// Assumes: 10 MHz clock, reset held 12 cycles
// Notes: Cycle counts start at the edge that samples the request pin
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ebhg_pkg::*;
;
  logic i_mclk, i_rst, want, i_grant_inhibit, i_sdram_burst_keep;
  logic i_bus_request_n, o_hold_pending, o_bus_oe_n, o_bus_grant_out_n;
  ebhg_xact_t i_xact;
  ebhg_bus_t i_bus, o_bus;
  int bad_count, checked, n;

  // Clock of 100 ns
  initial begin
    i_mclk = 1'h0;
    forever #50 i_mclk = ~i_mclk;
  end

  ebhg_top ebhg_top_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_bus_request_n(i_bus_request_n),
    .i_grant_inhibit(i_grant_inhibit), .i_sdram_burst_keep(i_sdram_burst_keep), .i_xact(i_xact),
    .i_bus(i_bus), .o_hold_pending(o_hold_pending), .o_bus(o_bus), .o_bus_oe_n(o_bus_oe_n),
    .o_bus_grant_out_n(o_bus_grant_out_n));
  ebhg_master ebhg_master_i (.i_mclk(i_mclk), .i_want(want), .o_bus_request_n(i_bus_request_n));

  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %0t seen %0h expected %0h", $time, s, e);
    end
  endtask
  task automatic tick();
    @(posedge i_mclk);
    #1;
  endtask
  // Ask or release; returns once the pin has moved
  task automatic req(input logic v);
    want = v;
    tick();
    #1;
  endtask
  // Count cycles until grant (g=1) or enable (g=0) reaches v
  task automatic wait_for(input logic g, input logic v, output int k);
    k = 0;
    do begin
      tick();
      k++;
    end while ((g ? o_bus_grant_out_n : o_bus_oe_n) !== v && k < 40);
    if ((g ? o_bus_grant_out_n : o_bus_oe_n) !== v) begin
      bad_count++;
      end_of_test();
    end
  endtask
  // Float, grant, release; fl of 0 skips the float delay check
  task automatic hold_cycle(input int fl);
    wait_for(1'h0, 1'h1, n);
    if (fl != 0) begin
      chk(n, fl);
    end
    wait_for(1'h1, 1'h0, n);
    chk(n, 1);
    req(1'h0);
    wait_for(1'h0, 1'h0, n);
    chk(n, MIN_DRIVE_P + 2);
    wait_for(1'h1, 1'h1, n);
    chk(n, 1);
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_reset();
    repeat (12) tick();
    chk(o_bus_grant_out_n, 1'h1);
    chk(o_bus_oe_n, 1'h0);
    chk(o_bus.ext_data_lines, 32'hFFFFFFFF);
    i_rst = 1'h0;
    i_bus.ext_data_lines = 32'hA5C30F1E;
    repeat (2) tick();
    chk(o_bus.ext_data_lines, 32'hA5C30F1E);
    $display("reset test done");
  endtask
  task automatic t_idle();
    req(1'h1);
    hold_cycle(MIN_FLOAT_P + 1);
    $display("idle hold test done");
  endtask
  task automatic t_inhibit();
    i_grant_inhibit = 1'h1;
    req(1'h1);
    repeat (20) tick();
    chk(o_bus_grant_out_n, 1'h1);
    chk(o_bus_oe_n, 1'h0);
    chk(o_hold_pending, 1'h0);
    i_grant_inhibit = 1'h0;
    hold_cycle(0);
    $display("inhibit test done");
  endtask
  // Async, other and unkept SDRAM traffic, then inhibit while draining
  task automatic t_async();
    i_xact.async_busy = 1'h1;
    req(1'h1);
    repeat (10) tick();
    chk(o_bus_oe_n, 1'h0);
    chk(o_hold_pending, 1'h1);
    i_xact = 4'h1;
    repeat (5) tick();
    chk(o_bus_oe_n, 1'h0);
    i_xact = 4'h6;
    repeat (12) tick();
    chk(o_bus_oe_n, 1'h0);
    i_grant_inhibit = 1'h1;
    i_xact = '0;
    repeat (5) tick();
    chk(o_bus_oe_n, 1'h0);
    chk(o_hold_pending, 1'h1);
    i_grant_inhibit = 1'h0;
    hold_cycle(0);
    $display("async access test done");
  endtask
  task automatic t_burst();
    i_sdram_burst_keep = 1'h1;
    i_xact = 4'h6;
    req(1'h1);
    repeat (5) tick();
    chk(o_bus_oe_n, 1'h0);
    repeat (5) tick();
    chk(o_bus_oe_n, 1'h1);
    i_xact = '0;
    hold_cycle(0);
    i_sdram_burst_keep = 1'h0;
    $display("burst keep test done");
  endtask

  // Main sequence
  initial begin
    i_rst = 1'h1;
    want = 1'h0;
    i_grant_inhibit = 1'h0;
    i_sdram_burst_keep = 1'h0;
    i_xact = '0;
    i_bus = '0;
    bad_count = 0;
    checked = 0;
    t_reset();
    t_idle();
    t_inhibit();
    t_async();
    t_burst();
    t_idle();
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
